// file: sarc_consts.svh
// Constants of the per-axis ramp and chopper configuration bank.
// Assumes inclusion by bare name from the package and the top module.
`ifndef SARC_CONSTS_SVH
`define SARC_CONSTS_SVH
// ------
// Register indices (byte address = 4 * index, axis in addr[11:10])
// ------
`define SARC_IX_RDIS 8'h0C
`define SARC_IX_LDIS 8'h0D
`define SARC_IX_MIDV 8'h10
`define SARC_IX_MAXD 8'h11
`define SARC_IX_FIND 8'h12
`define SARC_IX_STV 8'h13
`define SARC_IX_SPV 8'h14
`define SARC_IX_WAIT 8'h15
`define SARC_IX_THR 8'h16
`define SARC_IX_VDC 8'h17
`define SARC_IX_RPOL 8'h18
`define SARC_IX_LPOL 8'h19
`define SARC_IX_SOFT 8'h1A
`define SARC_IX_HSCH 8'h1B
`define SARC_IX_HSFS 8'h1C
`define SARC_IX_MEAS 8'h1D
`define SARC_IX_PDR 8'h1F
`define SARC_IX_LSPW 8'h20
`define SARC_IX_LSSS 8'h21
`define SARC_IX_REL 8'h7F
`define SARC_IX_MRES 8'h8C
`define SARC_IX_BLNK 8'hA2
`define SARC_IX_CMOD 8'hA3
`define SARC_IX_FDOF 8'hA4
// ------
// Field widths, storage layout and reset value
// ------
`define SARC_W_VEL 20
`define SARC_W_ACC 23
`define SARC_W_SV 18
`define SARC_W_WAIT 16
`define SARC_W_SPD 23
`define SARC_W_PDR 4
`define SARC_W_LSPW 10
`define SARC_W_LSSS 8
`define SARC_W_REL 2
`define SARC_W_MRES 4
`define SARC_W_BLNK 2
`define SARC_W_STEPS 9
`define SARC_MRES_MAX 4'h8
`define SARC_AXES 3
`define SARC_SLOTS 24
`define SARC_WORDS 72
`define SARC_AW 7
`define SARC_RST_VAL 32'h0
// ------
// Timing
// ------
`define SARC_CLK_NS 8
`define SARC_TICK_NS 32000
`define SARC_TICK_US 32
`define SARC_PD_UNIT_US 163840
`define SARC_TICK_CYC (`SARC_TICK_NS / `SARC_CLK_NS)
`define SARC_PD_UNIT_TICKS (`SARC_PD_UNIT_US / `SARC_TICK_US)
`endif

// file: sarc_pkg.sv
// Types shared by the configuration bank modules.
// Assumes sarc_consts.svh is on the include path.
`include "sarc_consts.svh"
package sarc_pkg;
  typedef enum logic [4:0] {S_MIDV, S_MAXD, S_FIND, S_STV, S_SPV,
    S_WAIT, S_THR, S_VDC, S_RPOL, S_LPOL, S_SOFT, S_HSCH, S_HSFS,
    S_MEAS, S_PDR, S_LSPW, S_LSSS, S_REL, S_MRES, S_BLNK, S_CMOD,
    S_FDOF, S_RDIS, S_LDIS} sarc_slot_t;
  typedef struct packed {
    logic ok;
    logic ro;
    logic [`SARC_AW-1:0] idx;
    logic [5:0] width;
  } sarc_dec_t;
  typedef struct packed {
    logic [`SARC_W_ACC-1:0] decel;
    logic two_phase;
    logic [`SARC_W_SV-1:0] start_v;
    logic [`SARC_W_SV-1:0] stop_v;
  } sarc_ramp_t;
  typedef struct packed {
    logic [`SARC_W_STEPS-1:0] steps;
    logic [`SARC_W_BLNK-1:0] blank;
    logic classic;
    logic fd_comp_en;
    logic [`SARC_W_REL-1:0] rel_origin;
    logic [`SARC_W_LSPW-1:0] ls_pulse;
    logic [`SARC_W_LSSS-1:0] ls_sens;
  } sarc_drv_t;
  typedef struct packed {
    logic hard_stop;
    logic soft_stop;
    logic fullstep;
    logic lac_off;
    logic ls_on;
    logic wait_busy;
    logic pwr_ramp;
    logic pwr_off;
  } sarc_stat_t;
  typedef enum {PD_RUN, PD_RAMP, PD_OFF} sarc_pd_t;
  typedef enum {RD_IDLE, RD_MEM, RD_RESP} sarc_rd_t;
endpackage

// file: sarc_cfg_if.sv
// Port bundle between the bus logic and the configuration memory.
// Assumes one clock shared by both ends.
`timescale 1ns/1ps
`include "sarc_consts.svh"
interface sarc_cfg_if;
  logic we;
  logic [`SARC_AW-1:0] waddr;
  logic [31:0] wdata;
  logic [3:0] wbe;
  logic [`SARC_AW-1:0] raddr;
  logic [31:0] rdata;
  logic [`SARC_WORDS-1:0][31:0] words;
  modport host(output we, waddr, wdata, wbe, raddr,
    input rdata, words);
  modport mem(input we, waddr, wdata, wbe, raddr,
    output rdata, words);
endinterface

// file: sarc_cfg_mem.sv
// Per-axis parameter store with byte-enable writes and registered read.
// Assumes the writer only presents in-range, writable word addresses.
`timescale 1ns/1ps
`include "sarc_consts.svh"
module sarc_cfg_mem (
  input wire logic clk_in,
  input wire logic rstn_in,
  sarc_cfg_if.mem cfg
);
  import sarc_pkg::*;
  logic [`SARC_WORDS-1:0][31:0] mem_reg;
  logic [`SARC_WORDS-1:0][31:0] mem_next;
  logic [31:0] rd_reg;
  logic [31:0] rd_next;

  // Merge enabled byte lanes into the addressed word
  always_comb begin
    mem_next = mem_reg;
    if (cfg.we) begin
      for (int b = 0; b < 4; b++) begin
        if (cfg.wbe[b]) begin
          mem_next[cfg.waddr][b*8 +: 8] = cfg.wdata[b*8 +: 8];
        end
      end
    end
    rd_next = mem_reg[cfg.raddr];
  end

  // Storage and read register
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      mem_reg <= {`SARC_WORDS{`SARC_RST_VAL}};
      rd_reg <= `SARC_RST_VAL;
    end else begin
      mem_reg <= mem_next;
      rd_reg <= rd_next;
    end
  end

  assign cfg.rdata = rd_reg;
  assign cfg.words = mem_reg;
endmodule

// file: sarc_sync.sv
// Two-flop synchroniser for the limit switch pins.
// Assumes asynchronous pin levels; only the second flop is read.
`timescale 1ns/1ps
module sarc_sync (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic [5:0] d_in,
  output logic [5:0] q_out
);
  logic [5:0] s1_reg;
  logic [5:0] s2_reg;

  // Two stages in series
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      s1_reg <= 6'h00;
      s2_reg <= 6'h00;
    end else begin
      s1_reg <= d_in;
      s2_reg <= s1_reg;
    end
  end

  assign q_out = s2_reg;
endmodule

// file: sarc_top.sv
// Per-axis ramp, limit switch and chopper configuration bank, three axes.
// Assumes an AXI4-Lite master, a ramp engine giving the velocity
// magnitude and a driver stage giving the measured speed.
//
// Notes on behaviour
// - mid velocity zero uses maximum values only
// - maximum deceleration above mid velocity
// - final deceleration from mid to stop
// - motion starts at start, ends at stop
// - wait configured ticks after reaching zero
// - one threshold for current control, fullstep
// - load stepping at or above minimum speed
// - polarity bit inverts limit switch input
// - soft stop ramps down on limit stop
// - high speed switches chopper mode
// - high speed switches to fullstep
// - measured speed readable, read only
// - power down ramp after standstill settles
// - load stepping reference pulse width setting
// - load stepping stall sensitivity setting
// - relative move origin select
// - microstep code selects steps per fullstep
// - comparator blank time select
// - chopper mode bit selects chopper type
// - disable comparator ending fast decay, classic mode only
// - disable bit ignores limit switch
`timescale 1ns/1ps
`include "sarc_consts.svh"
module sarc_top #(
  parameter int TICK_CYCLES = `SARC_TICK_CYC,
  parameter int PD_UNIT_TICKS = `SARC_PD_UNIT_TICKS
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic [11:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [11:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  input wire logic [2:0] lim_right_in,
  input wire logic [2:0] lim_left_in,
  input wire logic [2:0][22:0] meas_speed_in,
  input wire logic [2:0][22:0] act_vel_in,
  output sarc_pkg::sarc_ramp_t [2:0] ramp_out,
  output sarc_pkg::sarc_drv_t [2:0] drv_out,
  output sarc_pkg::sarc_stat_t [2:0] stat_out
);
  import sarc_pkg::*;

  // ------
  // Helper functions
  // ------

  // Width of the stored field of a slot
  function automatic logic [5:0] wid(input sarc_slot_t s);
    logic [5:0] w;
    w = 6'h01;
    case (s)
      S_MIDV: w = 6'(`SARC_W_VEL);
      S_MAXD, S_FIND: w = 6'(`SARC_W_ACC);
      S_STV, S_SPV: w = 6'(`SARC_W_SV);
      S_WAIT: w = 6'(`SARC_W_WAIT);
      S_THR, S_VDC, S_MEAS: w = 6'(`SARC_W_SPD);
      S_PDR: w = 6'(`SARC_W_PDR);
      S_LSPW: w = 6'(`SARC_W_LSPW);
      S_LSSS: w = 6'(`SARC_W_LSSS);
      S_REL: w = 6'(`SARC_W_REL);
      S_MRES: w = 6'(`SARC_W_MRES);
      S_BLNK: w = 6'(`SARC_W_BLNK);
      default: w = 6'h01;
    endcase
    return w;
  endfunction

  // Byte address to axis word, access kind and width
  function automatic sarc_dec_t dec(input logic [11:0] a);
    sarc_dec_t d;
    sarc_slot_t s;
    logic [7:0] ix;
    logic hit;
    d = '0;
    s = S_MIDV;
    ix = a[9:2];
    hit = (a[11:10] < 2'(`SARC_AXES));
    if (ix == `SARC_IX_MIDV) s = S_MIDV;
    else if (ix == `SARC_IX_MAXD) s = S_MAXD;
    else if (ix == `SARC_IX_FIND) s = S_FIND;
    else if (ix == `SARC_IX_STV) s = S_STV;
    else if (ix == `SARC_IX_SPV) s = S_SPV;
    else if (ix == `SARC_IX_WAIT) s = S_WAIT;
    else if (ix == `SARC_IX_THR) s = S_THR;
    else if (ix == `SARC_IX_VDC) s = S_VDC;
    else if (ix == `SARC_IX_RPOL) s = S_RPOL;
    else if (ix == `SARC_IX_LPOL) s = S_LPOL;
    else if (ix == `SARC_IX_SOFT) s = S_SOFT;
    else if (ix == `SARC_IX_HSCH) s = S_HSCH;
    else if (ix == `SARC_IX_HSFS) s = S_HSFS;
    else if (ix == `SARC_IX_MEAS) s = S_MEAS;
    else if (ix == `SARC_IX_PDR) s = S_PDR;
    else if (ix == `SARC_IX_LSPW) s = S_LSPW;
    else if (ix == `SARC_IX_LSSS) s = S_LSSS;
    else if (ix == `SARC_IX_REL) s = S_REL;
    else if (ix == `SARC_IX_MRES) s = S_MRES;
    else if (ix == `SARC_IX_BLNK) s = S_BLNK;
    else if (ix == `SARC_IX_CMOD) s = S_CMOD;
    else if (ix == `SARC_IX_FDOF) s = S_FDOF;
    else if (ix == `SARC_IX_RDIS) s = S_RDIS;
    else if (ix == `SARC_IX_LDIS) s = S_LDIS;
    else hit = 1'b0;
    d.ok = hit;
    d.ro = (s == S_MEAS);
    // Separate word per axis and slot
    d.idx = `SARC_AW'(a[11:10] * `SARC_SLOTS + s);
    d.width = wid(s);
    return d;
  endfunction

  // Microstep code to steps per fullstep
  function automatic logic [8:0] steps(input logic [3:0] c);
    logic [3:0] k;
    k = (c > `SARC_MRES_MAX) ? `SARC_MRES_MAX : c;
    return 9'h001 << k;
  endfunction

  // ------
  // Configuration memory and pin synchroniser
  // ------
  sarc_cfg_if cfg();

  sarc_cfg_mem u_mem (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .cfg(cfg)
  );

  logic [5:0] lim_sync;

  sarc_sync u_sync (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .d_in({lim_left_in, lim_right_in}),
    .q_out(lim_sync)
  );

  // ------
  // AXI4-Lite write channel
  // ------
  logic aw_hold_reg, aw_hold_next, w_hold_reg, w_hold_next;
  logic [11:0] aw_addr_reg, aw_addr_next;
  logic [31:0] w_data_reg, w_data_next;
  logic [3:0] w_strb_reg, w_strb_next;
  logic awready_reg, awready_next, wready_reg, wready_next;
  logic bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg, bresp_next;
  sarc_dec_t wdec;
  logic do_wr;

  // Take address and data in either order, then answer
  always_comb begin
    aw_hold_next = aw_hold_reg;
    aw_addr_next = aw_addr_reg;
    w_hold_next = w_hold_reg;
    w_data_next = w_data_reg;
    w_strb_next = w_strb_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    if (s_axi_awvalid_in && awready_reg) begin
      aw_hold_next = 1'b1;
      aw_addr_next = s_axi_awaddr_in;
    end
    if (s_axi_wvalid_in && wready_reg) begin
      w_hold_next = 1'b1;
      w_data_next = s_axi_wdata_in;
      w_strb_next = s_axi_wstrb_in;
    end
    if (bvalid_reg && s_axi_bready_in) begin
      bvalid_next = 1'b0;
    end
    wdec = dec(aw_addr_next);
    do_wr = aw_hold_next && w_hold_next && !bvalid_reg;
    if (do_wr) begin
      aw_hold_next = 1'b0;
      w_hold_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = (wdec.ok && !wdec.ro) ? 2'h0 : 2'h2;
    end
    awready_next = !aw_hold_next && !bvalid_next;
    wready_next = !w_hold_next && !bvalid_next;
  end

  // Write channel state
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      aw_hold_reg <= 1'b0;
      aw_addr_reg <= 12'h000;
      w_hold_reg <= 1'b0;
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= 2'h0;
    end else begin
      aw_hold_reg <= aw_hold_next;
      aw_addr_reg <= aw_addr_next;
      w_hold_reg <= w_hold_next;
      w_data_reg <= w_data_next;
      w_strb_reg <= w_strb_next;
      awready_reg <= awready_next;
      wready_reg <= wready_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
    end
  end

  // Memory write, data trimmed to the field width
  assign cfg.we = do_wr && wdec.ok && !wdec.ro;
  assign cfg.waddr = wdec.idx;
  assign cfg.wdata = w_data_next & ((32'h1 << wdec.width) - 32'h1);
  assign cfg.wbe = w_strb_next;

  // ------
  // AXI4-Lite read channel
  // ------
  sarc_rd_t rd_st_reg, rd_st_next;
  sarc_dec_t rdec_reg, rdec_next, rdec_now;
  logic arready_reg, arready_next, rvalid_reg, rvalid_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0] rresp_reg, rresp_next;

  // Address, memory cycle, then answer held until taken
  always_comb begin
    rd_st_next = rd_st_reg;
    rdec_next = rdec_reg;
    arready_next = arready_reg;
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    case (rd_st_reg)
      RD_IDLE: begin
        arready_next = 1'b1;
        if (s_axi_arvalid_in && arready_reg) begin
          rdec_next = rdec_now;
          arready_next = 1'b0;
          rd_st_next = RD_MEM;
        end
      end
      RD_MEM: begin
        rvalid_next = 1'b1;
        rresp_next = rdec_reg.ok ? 2'h0 : 2'h2;
        rdata_next = rdec_reg.ok ? cfg.rdata : 32'h00000000;
        if (rdec_reg.ok && rdec_reg.ro) begin
          // Live driver speed of the addressed axis
          rdata_next = 32'(meas_speed_in[rdec_reg.idx
            / `SARC_AW'(`SARC_SLOTS)]);
        end
        rd_st_next = RD_RESP;
      end
      default: begin
        if (s_axi_rready_in) begin
          rvalid_next = 1'b0;
          arready_next = 1'b1;
          rd_st_next = RD_IDLE;
        end
      end
    endcase
  end

  // Read channel state
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      rd_st_reg <= RD_IDLE;
      rdec_reg <= '0;
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= 2'h0;
    end else begin
      rd_st_reg <= rd_st_next;
      rdec_reg <= rdec_next;
      arready_reg <= arready_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
    end
  end

  assign rdec_now = dec(s_axi_araddr_in);
  assign cfg.raddr = rdec_now.idx;

  assign s_axi_awready_out = awready_reg;
  assign s_axi_wready_out = wready_reg;
  assign s_axi_bvalid_out = bvalid_reg;
  assign s_axi_bresp_out = bresp_reg;
  assign s_axi_arready_out = arready_reg;
  assign s_axi_rvalid_out = rvalid_reg;
  assign s_axi_rdata_out = rdata_reg;
  assign s_axi_rresp_out = rresp_reg;

  // ------
  // 32 us time base
  // ------
  logic [11:0] tick_cnt_reg, tick_cnt_next;
  logic tick_reg, tick_next;

  // One-cycle enable every TICK_CYCLES clocks
  always_comb begin
    tick_next = (tick_cnt_reg == 12'(TICK_CYCLES - 1));
    tick_cnt_next = tick_next ? 12'h000 : tick_cnt_reg + 12'h001;
  end

  // Divider state
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      tick_cnt_reg <= 12'h000;
      tick_reg <= 1'b0;
    end else begin
      tick_cnt_reg <= tick_cnt_next;
      tick_reg <= tick_next;
    end
  end

  // ------
  // Per-axis behaviour
  // ------
  for (genvar a = 0; a < `SARC_AXES; a++) begin : g_axis
    localparam int B = a * `SARC_SLOTS;
    sarc_ramp_t ramp_reg, ramp_next;
    sarc_drv_t drv_reg, drv_next;
    sarc_stat_t stat_reg, stat_next;
    sarc_pd_t pd_reg, pd_next;
    logic [15:0] wait_reg, wait_next;
    logic vz_reg, vz_next;
    logic [12:0] unit_reg, unit_next;
    logic [3:0] step_reg, step_next;
    logic [22:0] v, sp, thr, vdc;
    logic [19:0] midv;
    logic hs, stop_r, stop_l;

    // Ramp choice, limit stops, speed switching, chopper fields
    always_comb begin
      v = act_vel_in[a];
      sp = meas_speed_in[a];
      midv = cfg.words[B + S_MIDV][`SARC_W_VEL-1:0];
      thr = cfg.words[B + S_THR][`SARC_W_SPD-1:0];
      vdc = cfg.words[B + S_VDC][`SARC_W_SPD-1:0];
      ramp_next.two_phase = (midv != 20'h00000);
      ramp_next.decel = cfg.words[B + S_FIND][`SARC_W_ACC-1:0];
      if (midv == 20'h00000 || v > 23'(midv)) begin
        ramp_next.decel = cfg.words[B + S_MAXD][`SARC_W_ACC-1:0];
      end
      ramp_next.start_v = cfg.words[B + S_STV][`SARC_W_SV-1:0];
      ramp_next.stop_v = cfg.words[B + S_SPV][`SARC_W_SV-1:0];
      stop_r = (lim_sync[a] ^ cfg.words[B + S_RPOL][0])
        && !cfg.words[B + S_RDIS][0];
      stop_l = (lim_sync[3 + a] ^ cfg.words[B + S_LPOL][0])
        && !cfg.words[B + S_LDIS][0];
      stat_next.soft_stop = (stop_r || stop_l)
        && cfg.words[B + S_SOFT][0];
      stat_next.hard_stop = (stop_r || stop_l)
        && !cfg.words[B + S_SOFT][0];
      hs = (sp > thr);
      stat_next.lac_off = hs;
      stat_next.fullstep = hs && cfg.words[B + S_HSFS][0];
      stat_next.ls_on = (vdc != 23'h000000) && (sp >= vdc);
      drv_next.steps = steps(cfg.words[B + S_MRES][3:0]);
      drv_next.blank = cfg.words[B + S_BLNK][1:0];
      drv_next.classic = cfg.words[B + S_CMOD][0]
        ^ (hs && cfg.words[B + S_HSCH][0]);
      drv_next.fd_comp_en = !(drv_next.classic
        && cfg.words[B + S_FDOF][0]);
      drv_next.rel_origin = cfg.words[B + S_REL][1:0];
      drv_next.ls_pulse = cfg.words[B + S_LSPW][9:0];
      drv_next.ls_sens = cfg.words[B + S_LSSS][7:0];
      // Wait after reaching zero, reload beats countdown
      vz_next = (v == 23'h000000);
      wait_next = wait_reg;
      if (tick_reg && wait_reg != 16'h0000) begin
        wait_next = wait_reg - 16'h0001;
      end
      if (vz_next && !vz_reg) begin
        wait_next = cfg.words[B + S_WAIT][`SARC_W_WAIT-1:0];
      end
      stat_next.wait_busy = (wait_next != 16'h0000);
      // Current ramp down once standstill has settled
      pd_next = pd_reg;
      unit_next = unit_reg;
      step_next = step_reg;
      case (pd_reg)
        PD_RUN: begin
          if (vz_next && vz_reg && wait_reg == 16'h0000) begin
            step_next = cfg.words[B + S_PDR][3:0];
            unit_next = 13'h0000;
            pd_next = (step_next == 4'h0) ? PD_OFF : PD_RAMP;
          end
        end
        PD_RAMP: begin
          if (tick_reg) begin
            unit_next = unit_reg + 13'h0001;
            if (unit_reg == 13'(PD_UNIT_TICKS - 1)) begin
              unit_next = 13'h0000;
              step_next = step_reg - 4'h1;
              if (step_reg == 4'h1) begin
                pd_next = PD_OFF;
              end
            end
          end
        end
        default: begin
        end
      endcase
      if (!vz_next) begin
        pd_next = PD_RUN;
      end
      stat_next.pwr_ramp = (pd_next == PD_RAMP);
      stat_next.pwr_off = (pd_next == PD_OFF);
    end

    // Axis state and output registers
    always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
        ramp_reg <= '0;
        drv_reg <= '0;
        stat_reg <= '0;
        pd_reg <= PD_RUN;
        wait_reg <= 16'h0000;
        vz_reg <= 1'b1;
        unit_reg <= 13'h0000;
        step_reg <= 4'h0;
      end else begin
        ramp_reg <= ramp_next;
        drv_reg <= drv_next;
        stat_reg <= stat_next;
        pd_reg <= pd_next;
        wait_reg <= wait_next;
        vz_reg <= vz_next;
        unit_reg <= unit_next;
        step_reg <= step_next;
      end
    end

    assign ramp_out[a] = ramp_reg;
    assign drv_out[a] = drv_reg;
    assign stat_out[a] = stat_reg;
  end
endmodule

// file: sarc_top_chk.sv
// Checker of the bank's read answers and axis 0 output lanes.
// Assumes binding to sarc_top and its port names.
`timescale 1ns/1ps
module sarc_top_chk (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic s_axi_arvalid_in,
  input wire logic s_axi_arready_out,
  input wire logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  input wire logic [31:0] s_axi_rdata_out,
  input wire logic [2:0][22:0] act_vel_in,
  input wire sarc_pkg::sarc_drv_t [2:0] drv_out,
  input wire sarc_pkg::sarc_stat_t [2:0] stat_out
);
  import sarc_pkg::*;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  AST_RLAT: assert property (s_axi_arvalid_in && s_axi_arready_out
    |-> ##2 s_axi_rvalid_out) else $error("read answer late");
  AST_RHOLD: assert property (s_axi_rvalid_out && !s_axi_rready_in
    |=> s_axi_rvalid_out && $stable(s_axi_rdata_out))
    else $error("read data dropped");
  AST_RUN: assert property (act_vel_in[0] != 0
    |=> !stat_out[0].pwr_off && !stat_out[0].pwr_ramp)
    else $error("power down while moving");
  AST_WAIT: assert property (stat_out[0].wait_busy
    |-> !stat_out[0].pwr_off && !stat_out[0].pwr_ramp)
    else $error("power down before wait end");
  AST_OFF: assert property (stat_out[0].pwr_off
    |-> !stat_out[0].pwr_ramp) else $error("ramp and off together");
  AST_FDC: assert property ($past(rstn_in) && !drv_out[0].classic
    |-> drv_out[0].fd_comp_en) else $error("comparator off in spread mode");
  AST_STEPS: assert property ($past(rstn_in)
    |-> $onehot(drv_out[0].steps)) else $error("steps not a power of two");
  AST_STOP: assert property (!(stat_out[0].hard_stop
    && stat_out[0].soft_stop)) else $error("hard and soft stop together");
  AST_FULL: assert property (stat_out[0].fullstep
    |-> stat_out[0].lac_off) else $error("fullstep below threshold");
endmodule
bind sarc_top sarc_top_chk chk_i (.*);

// file: sarc_partner.sv
// Model of the driver stage and the limit switches of three axes.
// Assumes the bench sets speed and switch levels after clock edges.
`timescale 1ns/1ps
module sarc_partner (
  input wire logic clk_in,
  input wire logic [22:0] spd_in,
  input wire logic [5:0] hit_in,
  output logic [2:0][22:0] meas_out,
  output logic [5:0] lim_out
);
  // Driver reports last cycle's speed, switches follow the bench
  always_ff @(posedge clk_in) begin
    meas_out <= {3{spd_in}};
    lim_out <= hit_in;
  end
endmodule

// file: testbench.sv
// Self-checking bench of the three-axis configuration bank.
// Assumes sarc_partner stands in for the driver stage and switches.
`timescale 1ns/1ps
`include "sarc_consts.svh"
module testbench;
  import sarc_pkg::*;
  logic clk_in = 0, rstn_in = 0, awv = 0, wv = 0, bready = 1;
  logic arv = 0, rready = 1, awr, wrdy, bv, arr, rv;
  logic [11:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata;
  logic [1:0] bresp, rresp, ok = 2'h0, slv = 2'h2;
  logic [22:0] vel = 0, spd = 0;
  logic [5:0] hit = 0, lim;
  logic [2:0][22:0] meas;
  sarc_ramp_t [2:0] ramp;
  sarc_drv_t [2:0] drv;
  sarc_stat_t [2:0] st;
  int num_errors = 0, n_checks = 0;
  initial forever #4 clk_in = ~clk_in;
  sarc_partner pm (.clk_in, .spd_in(spd), .hit_in(hit), .meas_out(meas),
    .lim_out(lim));
  sarc_top #(.TICK_CYCLES(4), .PD_UNIT_TICKS(3)) dut (.clk_in, .rstn_in,
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awv),
    .s_axi_awready_out(awr), .s_axi_wdata_in(wdata),
    .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wv), .s_axi_wready_out(wrdy),
    .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bv),
    .s_axi_bready_in(bready), .s_axi_araddr_in(araddr),
    .s_axi_arvalid_in(arv), .s_axi_arready_out(arr),
    .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
    .s_axi_rvalid_out(rv), .s_axi_rready_in(rready),
    .lim_right_in(lim[2:0]), .lim_left_in(lim[5:3]), .meas_speed_in(meas),
    .act_vel_in({3{vel}}), .ramp_out(ramp), .drv_out(drv), .stat_out(st));
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      num_errors++;
      $display("wrong value at %0t: %h expected %h", $time, s, e);
    end
  endtask
  task automatic hold(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  function automatic logic [11:0] ad(input logic [1:0] x,
    input logic [7:0] i);
    return {x, i, 2'h0};
  endfunction
  // Bus write: hold each channel until taken, then wait for the answer
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
    input logic [1:0] er);
    awaddr <= a;
    wdata <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    do begin
      @(posedge clk_in);
      if (awr) awv <= 1'b0;
      if (wrdy) wv <= 1'b0;
    end while (!bv);
    chk(bresp, er);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e,
    input logic [1:0] er);
    araddr <= a;
    arv <= 1'b1;
    do begin
      @(posedge clk_in);
      if (arr) arv <= 1'b0;
    end while (!rv);
    chk(rdata, e);
    chk(rresp, er);
  endtask
  // Every register of axis 1 except the read-only measured speed is reset, sized and kept apart from axis 0
  task automatic t_regs();
    int ix[23] = '{12, 13, 16, 17, 18, 19, 20, 21, 22, 23, 24, 25, 26, 27,
      28, 31, 32, 33, 127, 140, 162, 163, 164};
    int w[23] = '{1, 1, 20, 23, 23, 18, 18, 16, 23, 23, 1, 1, 1, 1, 1, 4,
      10, 8, 2, 4, 2, 1, 1};
    foreach (ix[i]) begin
      rd(ad(2'h1, ix[i]), 32'h0, ok);
      wr(ad(2'h1, ix[i]), 32'hFFFFFFFF, ok);
      rd(ad(2'h1, ix[i]), (32'h1 << w[i]) - 1, ok);
      rd(ad(2'h0, ix[i]), 32'h0, ok);
    end
    wr(ad(2'h3, `SARC_IX_MIDV), 32'h1, slv);
    rd(ad(2'h0, 8'h1E), 32'h0, slv);
  endtask
  task automatic t_meas();
    spd <= 23'h4ABCD;
    hold(3);
    rd(ad(2'h0, `SARC_IX_MEAS), 32'h4ABCD, ok);
    wr(ad(2'h0, `SARC_IX_MEAS), 32'h1, slv);
  endtask
  task automatic t_ramp();
    wr(ad(2'h0, `SARC_IX_MAXD), 32'h5, ok);
    wr(ad(2'h0, `SARC_IX_FIND), 32'h7, ok);
    wr(ad(2'h0, `SARC_IX_STV), 32'h3, ok);
    wr(ad(2'h0, `SARC_IX_SPV), 32'h9, ok);
    vel <= 23'h32;
    hold(2);
    chk(ramp[0].decel, 32'h5);
    chk(ramp[0].start_v, 32'h3);
    chk(ramp[0].stop_v, 32'h9);
    wr(ad(2'h0, `SARC_IX_MIDV), 32'h64, ok);
    vel <= 23'hC8;
    hold(2);
    chk(ramp[0].decel, 32'h5);
    vel <= 23'h64;
    hold(2);
    chk(ramp[0].decel, 32'h7);
    chk(ramp[0].two_phase, 32'h1);
    vel <= 23'h0;
  endtask
  task automatic t_thr();
    wr(ad(2'h0, `SARC_IX_THR), 32'h64, ok);
    wr(ad(2'h0, `SARC_IX_HSFS), 32'h1, ok);
    wr(ad(2'h0, `SARC_IX_HSCH), 32'h1, ok);
    wr(ad(2'h0, `SARC_IX_VDC), 32'h78, ok);
    for (int s = 0; s < 2; s++) begin
      spd <= s ? 23'h64 : 23'h96;
      hold(3);
      chk(st[0].fullstep, !s);
      chk(st[0].lac_off, !s);
      chk(drv[0].classic, !s);
      chk(st[0].ls_on, !s);
    end
    wr(ad(2'h0, `SARC_IX_HSCH), 32'h0, ok);
  endtask
  task automatic t_lim();
    hit <= 6'h01;
    hold(5);
    chk(st[0].hard_stop, 32'h1);
    wr(ad(2'h0, `SARC_IX_RDIS), 32'h1, ok);
    hold(2);
    chk(st[0].hard_stop, 32'h0);
    wr(ad(2'h0, `SARC_IX_RDIS), 32'h0, ok);
    wr(ad(2'h0, `SARC_IX_RPOL), 32'h1, ok);
    hit <= 6'h00;
    hold(5);
    chk(st[0].hard_stop, 32'h1);
    wr(ad(2'h0, `SARC_IX_SOFT), 32'h1, ok);
    hold(2);
    chk({st[0].hard_stop, st[0].soft_stop}, 32'h1);
    wr(ad(2'h0, `SARC_IX_RPOL), 32'h0, ok);
  endtask
  task automatic t_pd();
    wr(ad(2'h0, `SARC_IX_WAIT), 32'h2, ok);
    wr(ad(2'h0, `SARC_IX_PDR), 32'h3, ok);
    vel <= 23'hA;
    hold(3);
    vel <= 23'h0;
    hold(3);
    chk(st[0].wait_busy, 32'h1);
    hold(11);
    chk(st[0].pwr_ramp, 32'h1);
    hold(45);
    chk(st[0].pwr_off, 32'h1);
  endtask
  task automatic t_drv();
    for (int c = 0; c < 10; c++) begin
      wr(ad(2'h0, `SARC_IX_MRES), c, ok);
      hold(1);
      chk(drv[0].steps, c > 8 ? 256 : 1 << c);
    end
    for (int r = 0; r < 3; r++) begin
      wr(ad(2'h0, `SARC_IX_REL), r, ok);
      hold(1);
      chk(drv[0].rel_origin, r);
    end
    wr(ad(2'h0, `SARC_IX_CMOD), 32'h1, ok);
    wr(ad(2'h0, `SARC_IX_FDOF), 32'h1, ok);
    wr(ad(2'h0, `SARC_IX_BLNK), 32'h2, ok);
    wr(ad(2'h0, `SARC_IX_LSPW), 32'h3FF, ok);
    wr(ad(2'h0, `SARC_IX_LSSS), 32'hA5, ok);
    hold(1);
    chk({drv[0].classic, drv[0].fd_comp_en}, 32'h2);
    chk(drv[0].blank, 32'h2);
    chk(drv[0].ls_pulse, 32'h3FF);
    chk(drv[0].ls_sens, 32'hA5);
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Main sequence after a 16 cycle reset
  initial begin
    hold(16);
    rstn_in <= 1'b1;
    hold(2);
    t_regs();
    t_meas();
    t_ramp();
    t_thr();
    t_lim();
    t_pd();
    t_drv();
    final_report();
  end
  // Watchdog against a stalled handshake
  initial begin
    #400000;
    num_errors++;
    final_report();
  end
endmodule
